// ==== rtl/modbus_timing_pkg.sv ====
// package: register map, field layout, resets and timing for the serial-line sequencer
package modbus_timing_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INIT_DELAY = 8'h04;
  localparam logic [7:0] OFF_RETRY = 8'h08;
  localparam logic [7:0] OFF_RESP_TMO = 8'h0C;
  localparam logic [7:0] OFF_IFD = 8'h10;
  localparam logic [7:0] OFF_ICT = 8'h14;
  localparam logic [7:0] OFF_LINE_RATE = 8'h18;
  localparam logic [7:0] OFF_HALF_BIT = 8'h1C;
  localparam logic [7:0] OFF_STATION = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] OFF_INT_STAT = 8'h28;
  localparam logic [7:0] OFF_INT_MASK = 8'h2C;

  // control field positions
  localparam int CTRL_ASCII_BIT = 0;
  localparam int CTRL_SLAVE_BIT = 1;
  localparam int CTRL_ENABLE_BIT = 2;

  // status field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_TRIES_LSB = 4;
  localparam int STAT_IN_FRAME_BIT = 8;

  // reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [14:0] INIT_DELAY_RST = 15'h0000;
  localparam logic [2:0] RETRY_RST = 3'h3;
  localparam logic [16:0] RESP_TMO_RST = 17'h0_03E8;
  localparam logic [8:0] IFD_RST = 9'h000;
  localparam logic [8:0] ICT_RST = 9'h000;
  localparam logic [17:0] LINE_RATE_RST = 18'h0_2580;
  localparam logic [15:0] HALF_BIT_RST = 16'h1458;
  localparam logic [7:0] STATION_RST = 8'h01;
  localparam logic [3:0] INT_MASK_RST = 4'h0;

  // line rate above which the char-time defaults give way to fixed values
  localparam logic [17:0] RATE_LIMIT = 18'h0_4B00;
  // eleven bits per character, counted in half bits
  localparam int BITS_PER_CHAR = 11;
  localparam logic [7:0] IFD_HALF_BITS = 8'(BITS_PER_CHAR * 7);
  localparam logic [7:0] ICT_HALF_BITS = 8'(BITS_PER_CHAR * 3);

  // timing figures in their own units
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int FAST_IFD_US = 1750;
  localparam int FAST_ICT_US = 750;
  localparam int MS_CYCLES_DOC = MS_NS / CLK_PERIOD_NS;
  localparam int FAST_IFD_CYCLES_DOC = FAST_IFD_US * 1000 / CLK_PERIOD_NS;
  localparam int FAST_ICT_CYCLES_DOC = FAST_ICT_US * 1000 / CLK_PERIOD_NS;

  // master sequencer states
  typedef enum logic [2:0] {
    S_BOOT = 3'b000,
    S_HOLD = 3'b001,
    S_IDLE = 3'b010,
    S_SEND = 3'b011,
    S_WAIT = 3'b100,
    S_GAP = 3'b101
  } seq_state_t;

  // decoded receive stream from the character codec
  typedef struct packed {
    logic valid;
    logic frame_end;
    logic [7:0] data;
  } ser_rx_t;

  // sticky event layout, shared by status and mask
  typedef struct packed {
    logic req_accept;
    logic frame_drop;
    logic cmd_timeout;
    logic cmd_done;
  } ev_t;

endpackage : modbus_timing_pkg

// ==== rtl/modbus_serial_master_timing.sv ====
// serial-line transaction sequencer, frame timing and station filter with apb registers
//
// Behaviour
// - RTU or ASCII framing, RTU after reset
// - first request held off by initial delay
// - resend same request up to retry count
// - response timeout abandons request, carries on
// - RTU inter-frame gap, zero means 3.5 chars
// - fast line uses fixed gap and timeout
// - RTU inter-char timeout, zero means 1.5 chars
// - character time counts eleven bit periods
// - slave role accepts only own station id
`timescale 1ns/1ps
module modbus_serial_master_timing
  import modbus_timing_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DOC,
  parameter int FAST_IFD_CYCLES = FAST_IFD_CYCLES_DOC,
  parameter int FAST_ICT_CYCLES = FAST_ICT_CYCLES_DOC
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // command source
  input wire logic cmd_valid,
  output logic cmd_taken,
  output ev_t events,
  // serial side
  output logic tx_start,
  input wire logic tx_done,
  input wire ser_rx_t rx,
  // interrupt
  output logic irq
);

  // configuration registers
  logic [2:0] ctrl;
  logic [14:0] init_delay;
  logic [2:0] retry;
  logic [16:0] resp_tmo;
  logic [8:0] ifd;
  logic [8:0] ict;
  logic [17:0] line_rate;
  logic [15:0] half_bit;
  logic [7:0] station;
  logic [3:0] int_stat;
  logic [3:0] int_mask;

  // sequencer and receiver state
  seq_state_t state;
  logic [33:0] tmr;
  logic [2:0] tries;
  logic in_frame;
  logic [7:0] frame_addr;
  logic [33:0] gap_cnt;
  logic drop_now;
  // one flop per event pulse, so each has a single driving process
  logic ev_done;
  logic ev_timeout;
  logic ev_drop;
  logic ev_accept;

  // combinational helpers
  logic ascii;
  logic slave;
  logic fast_line;
  logic [33:0] ifd_cyc;
  logic [33:0] ict_cyc;
  logic frame_good;
  logic apb_access;
  logic apb_wr;
  ev_t ev_set;
  logic [31:0] next_prdata;
  logic next_pslverr;

  // milliseconds to clock cycles
  function automatic logic [33:0] ms_cyc(input logic [16:0] ms);
    ms_cyc = 34'(ms) * 34'(MS_CYCLES);
  endfunction : ms_cyc

  // rtu gap: configured ms, char-time default, or fixed figure on a fast line
  function automatic logic [33:0] gap_cyc(input logic [8:0] ms, input logic [7:0] half_bits,
                                          input logic fast, input int fast_cycles);
    if (fast) begin
      gap_cyc = 34'(fast_cycles);
    end else if (ms == 9'h000) begin
      gap_cyc = 34'(half_bits) * 34'(half_bit);
    end else begin
      gap_cyc = ms_cyc(17'(ms));
    end
  endfunction : gap_cyc

  // mode and timing decode
  assign ascii = ctrl[CTRL_ASCII_BIT];
  assign slave = ctrl[CTRL_SLAVE_BIT];
  assign fast_line = line_rate > RATE_LIMIT;
  assign ifd_cyc = gap_cyc(ifd, IFD_HALF_BITS, fast_line, FAST_IFD_CYCLES);
  assign ict_cyc = gap_cyc(ict, ICT_HALF_BITS, fast_line, FAST_ICT_CYCLES);
  assign drop_now = !ascii && in_frame && !rx.valid && (gap_cnt > ict_cyc);
  assign frame_good = rx.frame_end && in_frame && !drop_now;
  assign apb_access = psel && penable && !pready;
  assign apb_wr = apb_access && pwrite;

  // receiver framing: first byte is the station address, silence drops an RTU frame
  always_ff @(posedge clk) begin
    if (!rstn) begin
      in_frame <= 1'b0;
      frame_addr <= 8'h00;
      gap_cnt <= 34'h0_0000_0000;
    end else if (ce) begin
      if (rx.valid) begin
        gap_cnt <= 34'h0_0000_0000;
        in_frame <= 1'b1;
        if (!in_frame) begin
          frame_addr <= rx.data;
        end
      end else if (drop_now || rx.frame_end) begin
        in_frame <= 1'b0;
        gap_cnt <= 34'h0_0000_0000;
      end else if (in_frame && (gap_cnt <= ict_cyc)) begin
        gap_cnt <= gap_cnt + 34'h0_0000_0001; // saturates just past the limit
      end
    end
  end

  // master sequencer: boot hold-off, send, wait, retry, gap
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= S_BOOT;
      tmr <= 34'h0_0000_0000;
      tries <= 3'h0;
      tx_start <= 1'b0;
      cmd_taken <= 1'b0;
      ev_done <= 1'b0;
      ev_timeout <= 1'b0;
    end else if (ce) begin
      tx_start <= 1'b0;
      cmd_taken <= 1'b0;
      ev_done <= 1'b0;
      ev_timeout <= 1'b0;
      unique case (state)
        S_BOOT: begin
          if (ctrl[CTRL_ENABLE_BIT] && !slave) begin
            tmr <= ms_cyc(17'(init_delay));
            state <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (tmr == 34'h0_0000_0000) begin
            state <= S_IDLE;
          end else begin
            tmr <= tmr - 34'h0_0000_0001;
          end
        end
        S_IDLE: begin
          if (slave || !ctrl[CTRL_ENABLE_BIT]) begin
            state <= S_BOOT; // a role change or disable restarts the hold-off
          end else if (cmd_valid) begin
            cmd_taken <= 1'b1;
            tries <= 3'h0;
            tx_start <= 1'b1;
            state <= S_SEND;
          end
        end
        S_SEND: begin
          if (tx_done) begin
            tmr <= ms_cyc(resp_tmo);
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (frame_good) begin
            ev_done <= 1'b1;
            tmr <= ifd_cyc;
            state <= S_GAP;
          end else if (tmr != 34'h0_0000_0000) begin
            tmr <= tmr - 34'h0_0000_0001;
          end else if (tries < retry) begin
            tries <= tries + 3'h1;
            tx_start <= 1'b1;
            state <= S_SEND;
          end else begin
            ev_timeout <= 1'b1;
            tmr <= ifd_cyc;
            state <= S_GAP;
          end
        end
        S_GAP: begin
          // ascii framing has no inter-frame gap
          if (ascii || tmr == 34'h0_0000_0000) begin
            state <= S_IDLE;
          end else begin
            tmr <= tmr - 34'h0_0000_0001;
          end
        end
        default: begin
          state <= S_BOOT;
        end
      endcase
    end
  end

  // receive-side events
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ev_drop <= 1'b0;
      ev_accept <= 1'b0;
    end else if (ce) begin
      ev_drop <= drop_now;
      ev_accept <= slave && frame_good && (frame_addr == station);
    end
  end

  // pack the event flops in status-bit order
  assign ev_set = {ev_accept, ev_drop, ev_timeout, ev_done};
  assign events = ev_set;

  // configuration writes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl <= CTRL_RST;
      init_delay <= INIT_DELAY_RST;
      retry <= RETRY_RST;
      resp_tmo <= RESP_TMO_RST;
      ifd <= IFD_RST;
      ict <= ICT_RST;
      line_rate <= LINE_RATE_RST;
      half_bit <= HALF_BIT_RST;
      station <= STATION_RST;
      int_mask <= INT_MASK_RST;
    end else if (ce && apb_wr) begin
      unique case (paddr)
        OFF_CTRL: ctrl <= pwdata[2:0];
        OFF_INIT_DELAY: init_delay <= pwdata[14:0];
        OFF_RETRY: retry <= pwdata[2:0];
        OFF_RESP_TMO: resp_tmo <= pwdata[16:0];
        OFF_IFD: ifd <= pwdata[8:0];
        OFF_ICT: ict <= pwdata[8:0];
        OFF_LINE_RATE: line_rate <= pwdata[17:0];
        OFF_HALF_BIT: half_bit <= pwdata[15:0];
        OFF_STATION: station <= pwdata[7:0];
        OFF_INT_MASK: int_mask <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // sticky events, a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      int_stat <= 4'h0;
    end else if (ce) begin
      if (apb_wr && paddr == OFF_INT_STAT) begin
        int_stat <= (int_stat & ~pwdata[3:0]) | ev_set;
      end else begin
        int_stat <= int_stat | ev_set;
      end
    end
  end

  // interrupt level, one cycle behind the sticky bits
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(int_stat & int_mask);
    end
  end

  // read mux and error answer for unmapped offsets
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    unique case (paddr)
      OFF_CTRL: next_prdata = 32'(ctrl);
      OFF_INIT_DELAY: next_prdata = 32'(init_delay);
      OFF_RETRY: next_prdata = 32'(retry);
      OFF_RESP_TMO: next_prdata = 32'(resp_tmo);
      OFF_IFD: next_prdata = 32'(ifd);
      OFF_ICT: next_prdata = 32'(ict);
      OFF_LINE_RATE: next_prdata = 32'(line_rate);
      OFF_HALF_BIT: next_prdata = 32'(half_bit);
      OFF_STATION: next_prdata = 32'(station);
      OFF_STATUS: begin
        next_prdata[STAT_STATE_LSB +: 3] = state;
        next_prdata[STAT_TRIES_LSB +: 3] = tries;
        next_prdata[STAT_IN_FRAME_BIT] = in_frame;
      end
      OFF_INT_STAT: next_prdata = 32'(int_stat);
      OFF_INT_MASK: next_prdata = 32'(int_mask);
      default: next_pslverr = 1'b1;
    endcase
  end

  // apb answer: one wait state, pready for exactly one cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= apb_access;
      pslverr <= apb_access && next_pslverr;
      if (apb_access && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

endmodule : modbus_serial_master_timing

// ==== verif/modbus_timing_monitor.sv ====
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module modbus_timing_monitor
  import modbus_timing_pkg::*;
#(
  parameter int MS_CYCLES = 10,
  parameter int FAST_ICT_CYCLES = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // observed ports
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cmd_valid,
  input wire logic cmd_taken,
  input wire ev_t events,
  input wire logic tx_start,
  input wire ser_rx_t rx
);
  localparam int MIN_GAP = (MS_CYCLES < FAST_ICT_CYCLES) ? MS_CYCLES : FAST_ICT_CYCLES;
  int gap_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // cycles since last byte, saturating so it never wraps
  always_ff @(posedge clk) begin
    if (rx.valid) gap_cnt <= 0;
    else if (gap_cnt < 1000000) gap_cnt <= gap_cnt + 1;
  end
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer not after one wait");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_take_needs_valid: assert property (cmd_taken |-> $past(cmd_valid))
    else $error("command taken without request");
  a_take_sends: assert property (cmd_taken |-> tx_start)
    else $error("taken command not sent");
  a_send_pulse: assert property (tx_start |=> !tx_start)
    else $error("send strobe longer than one cycle");
  a_done_by_frame: assert property (events.cmd_done |-> $past(rx.frame_end))
    else $error("done without received frame");
  // ascii has no gap, so a fresh command may start two cycles on, but never a bare resend
  a_no_resend: assert property (events.cmd_timeout |=> !tx_start ##1 (!tx_start || cmd_taken))
    else $error("resend after give-up");
  a_gap_after: assert property (events.cmd_done || events.cmd_timeout |=> !cmd_taken)
    else $error("next command without gap");
  a_accept_frame: assert property (events.req_accept |-> $past(rx.frame_end))
    else $error("accept without frame");
  a_drop_after_gap: assert property (events.frame_drop |-> gap_cnt >= MIN_GAP)
    else $error("frame dropped too early");
  c_done: cover property (events.cmd_done);
  c_timeout: cover property (events.cmd_timeout);
  c_drop: cover property (events.frame_drop);
  c_accept: cover property (events.req_accept);
endmodule : modbus_timing_monitor

bind modbus_serial_master_timing modbus_timing_monitor #(.MS_CYCLES(MS_CYCLES), .FAST_ICT_CYCLES(FAST_ICT_CYCLES))
  u_mon (.clk, .rstn, .psel, .penable, .pready, .pslverr, .cmd_valid, .cmd_taken, .events, .tx_start, .rx);

// ==== verif/modbus_field_dev.sv ====
// field device model: finishes sends, then replies, stays silent or breaks off
`timescale 1ns/1ps
module modbus_field_dev
  import modbus_timing_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // line side
  input wire logic tx_start,
  output logic tx_done,
  output ser_rx_t rx
);
  int mode = 0; // 0 silent, 1 reply, 2 one byte then silence
  initial begin
    tx_done = 0;
    rx = '0;
  end
  // bytes two cycles apart; idle data inverted so no stale value lingers
  task automatic send(input logic [7:0] adr, input int n, input logic fin);
    for (int i = 0; i <= n; i++) begin
      rx.valid <= 1;
      rx.data <= (i == 0) ? adr : 8'(i);
      @(posedge clk);
      rx.valid <= 0;
      rx.data <= ~rx.data;
      @(posedge clk);
    end
    rx.frame_end <= fin;
    @(posedge clk);
    rx.frame_end <= 0;
  endtask : send
  // each send strobe: finish the line transfer, then answer per mode
  always @(posedge clk) if (rstn && tx_start) begin
    repeat (3) @(posedge clk);
    tx_done <= 1;
    @(posedge clk);
    tx_done <= 0;
    repeat (4) @(posedge clk);
    if (mode != 0) send(8'h11, (mode == 1) ? 3 : 0, mode == 1);
  end
endmodule : modbus_field_dev

// ==== verif/modbus_serial_master_timing_bench.sv ====
// self-checking bench for the serial-line sequencer
`timescale 1ns/1ps
module modbus_serial_master_timing_bench;
  import modbus_timing_pkg::*;
  logic clk = 0, rstn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, cmd_valid = 0, err;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, cmd_taken, tx_start, tx_done, irq;
  ev_t events;
  ser_rx_t rx;
  int miscompares = 0, tests_run = 0, cyc = 0, n_tx = 0, t_take = 0, t_done = 0, t_ev = 0, t_rx = 0, t_drop = 0;
  int n_ev[4] = '{0, 0, 0, 0};
  modbus_serial_master_timing #(.MS_CYCLES(10), .FAST_IFD_CYCLES(20), .FAST_ICT_CYCLES(10)) uut (.clk, .rstn,
    .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cmd_valid, .cmd_taken, .events,
    .tx_start, .tx_done, .rx, .irq);
  modbus_field_dev dev (.clk, .rstn, .tx_start, .tx_done, .rx);
  initial forever #5 clk = ~clk;
  // bookkeeping and hang guard; request drops once taken
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx_start) n_tx <= n_tx + 1;
    if (cmd_taken) t_take <= cyc;
    if (cmd_taken) cmd_valid <= 0;
    if (events.cmd_done) t_done <= cyc;
    if (rx.valid) t_rx <= cyc;
    if (events.frame_drop) t_drop <= cyc;
    for (int i = 0; i < 4; i++) if (events[i]) n_ev[i] <= n_ev[i] + 1;
    if (cyc == 30000) begin
      miscompares++;
      print_verdict();
    end
  end
  task print_verdict;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // apb transfer: setup, access held until ready, then one idle cycle
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 0;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : apb
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rdc
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    rdc(OFF_CTRL, 32'h0000_0000);
    rdc(OFF_INIT_DELAY, 32'h0000_0000);
    rdc(OFF_RETRY, 32'h0000_0003);
    rdc(OFF_RESP_TMO, 32'h0000_03E8);
    rdc(OFF_IFD, 32'h0000_0000);
    rdc(OFF_ICT, 32'h0000_0000);
    rdc(OFF_STATION, 32'h0000_0001);
    rdc(8'h40, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    $display("reset values done");
    // fast line, short hold-off, one retry, 10 ms answer window
    apb(1, OFF_LINE_RATE, 32'h0000_9600);
    apb(1, OFF_INIT_DELAY, 32'h0000_0003);
    apb(1, OFF_RETRY, 32'h0000_0001);
    apb(1, OFF_RESP_TMO, 32'h0000_000A);
    apb(1, OFF_INT_MASK, 32'h0000_0001);
    dev.mode = 1;
    cmd_valid <= 1;
    apb(1, OFF_CTRL, 32'h0000_0004);
    t_ev = cyc;
    @(posedge clk iff events.cmd_done);
    cmd_valid <= 1;
    dev.mode = 0;
    @(posedge clk);
    check(32'(t_take - t_ev >= 28), 32'h0000_0001);
    check(32'(n_tx), 32'h0000_0001);
    @(posedge clk);
    check({31'h0, irq}, 32'h0000_0001);
    rdc(OFF_INT_STAT, 32'h0000_0001);
    apb(1, OFF_INT_STAT, 32'h0000_0001);
    @(posedge clk);
    check({31'h0, irq}, 32'h0000_0000);
    $display("answered request done");
    @(posedge clk iff events.cmd_timeout);
    @(posedge clk);
    check(32'(t_take - t_done >= 20), 32'h0000_0001);
    check(32'(n_tx), 32'h0000_0003);
    check(32'(n_ev[1]), 32'h0000_0001);
    $display("retry and give-up done");
    // broken-off reply on a fast line: fixed timeout drops each RTU try, none in ascii
    dev.mode = 2;
    cmd_valid <= 1;
    @(posedge clk iff events.cmd_timeout);
    @(posedge clk);
    check(32'(n_ev[2]), 32'h0000_0002);
    check(32'(n_ev[1]), 32'h0000_0002);
    apb(1, OFF_CTRL, 32'h0000_0005);
    cmd_valid <= 1;
    @(posedge clk iff events.cmd_timeout);
    @(posedge clk);
    check(32'(n_ev[2]), 32'h0000_0002);
    $display("gap drop done");
    // slave role: only own station accepted
    apb(1, OFF_STATION, 32'h0000_0005);
    apb(1, OFF_CTRL, 32'h0000_0006);
    repeat (40) @(posedge clk);
    dev.send(8'h05, 2, 1);
    dev.send(8'h06, 2, 1);
    repeat (3) @(posedge clk);
    check(32'(n_ev[3]), 32'h0000_0001);
    $display("station filter done");
    // slow line, char-time timeout: 1.5 chars of 11 bits, one cycle per half bit
    apb(1, OFF_LINE_RATE, 32'h0000_2580);
    apb(1, OFF_HALF_BIT, 32'h0000_0001);
    dev.send(8'h05, 0, 0);
    repeat (40) @(posedge clk);
    check(32'(t_drop - t_rx), 32'(3 * BITS_PER_CHAR + 3));
    $display("char-time drop done");
    print_verdict();
  end
endmodule : modbus_serial_master_timing_bench
